// *** hdl/rfpbc_map.vh ***
// register map, field positions and reset values of the rf port and bias control block
// Operation
// - control bits live in control register 07
// - bit 12 picks dual or single port
// - dual port: input pair receive only
// - bit 14 low tri-states the bias output
// - bit 13 inverts only dual port enabled
// - single port: high transmit, low receive
// - dual port: transmit and receive opposite levels
// - level from radio state, then port mode
`ifndef RFPBC_MAP_VH
`define RFPBC_MAP_VH
`define RFPBC_CTRL_REG_NUM 8'h07
`define RFPBC_CTRL_RESET 16'h0000
`define RFPBC_OUT_RESET 1'h0
`define RFPBC_BIT_PORT_SEL 4'hc
`define RFPBC_BIT_POL_INV 4'hd
`define RFPBC_BIT_OUT_EN 4'he
`define RFPBC_RADIO_IDLE 2'h0
`define RFPBC_RADIO_RX 2'h1
`define RFPBC_RADIO_TX 2'h2
`endif

// *** hdl/rfpbc_level.v ***
// combinational level decode for the bias control output
`timescale 1ns/1ns
module rfpbc_level (
   input wire single_port_i,
   input wire invert_i,
   input wire [1:0] radio_state_i,
   output reg level_o
);
`include "rfpbc_map.vh"
   always @* begin
      level_o = 1'b0;
      // radio state first, then port mode
      if (radio_state_i == `RFPBC_RADIO_TX || radio_state_i == `RFPBC_RADIO_RX) begin
         if (single_port_i) begin
            level_o = (radio_state_i == `RFPBC_RADIO_TX);
         end else begin
            // opposite levels, polarity chosen by invert
            level_o = (radio_state_i == `RFPBC_RADIO_TX) ^ invert_i;
         end
      end else begin
         level_o = 1'b0;
      end
   end
endmodule

// *** hdl/rfpbc_top.v ***
// rf port arrangement and bias control output logic
`timescale 1ns/1ns
module rfpbc_top (
   input wire clk_i,
   input wire rst_i,
   input wire ctrl_wr_i,
   input wire [7:0] ctrl_addr_i,
   input wire [15:0] ctrl_wdata_i,
   input wire [1:0] radio_state_i,
   output reg [15:0] ctrl_rdata_o,
   output reg rf_bias_ctrl_out_o,
   output reg rf_bias_ctrl_oe_o,
   output reg rf_in_rx_switch_en_o,
   output reg rf_in_tx_amp_en_o,
   output reg amp_out_tx_amp_en_o,
   output reg rf_in_bidir_o
);
`include "rfpbc_map.vh"

   // control word and its fields
   reg [15:0] ctrl;
   wire port_arrangement_select;
   wire bias_out_enable;
   wire bias_polarity_invert;

   // register number decode
   wire ctrl_hit;
   wire ctrl_take;

   // radio state decode and bias level
   wire is_tx;
   wire is_rx;
   wire level;

   // next values of every flip-flop
   reg [15:0] next_ctrl;
   reg [15:0] next_rdata;
   reg next_bias_out;
   reg next_bias_oe;
   reg next_rx_switch_en;
   reg next_in_tx_amp_en;
   reg next_out_tx_amp_en;
   reg next_bidir;

   // one bit of the control word
   function ctrl_bit;
      input [15:0] word;
      input [3:0] pos;
      begin
         ctrl_bit = word[pos];
      end
   endfunction

   // register number names the control register
   function addr_is_ctrl;
      input [7:0] addr;
      begin
         addr_is_ctrl = (addr == `RFPBC_CTRL_REG_NUM);
      end
   endfunction

   // radio state matches a code, the spare code counts as idle
   function radio_is;
      input [1:0] state;
      input [1:0] code;
      begin
         case (state)
            `RFPBC_RADIO_TX: begin
               radio_is = (code == `RFPBC_RADIO_TX);
            end
            `RFPBC_RADIO_RX: begin
               radio_is = (code == `RFPBC_RADIO_RX);
            end
            default: begin
               radio_is = 1'h0;
            end
         endcase
      end
   endfunction

   assign port_arrangement_select = ctrl_bit(ctrl, `RFPBC_BIT_PORT_SEL);
   assign bias_out_enable = ctrl_bit(ctrl, `RFPBC_BIT_OUT_EN);
   assign bias_polarity_invert = ctrl_bit(ctrl, `RFPBC_BIT_POL_INV);

   assign ctrl_hit = addr_is_ctrl(ctrl_addr_i);
   assign ctrl_take = ctrl_wr_i & addr_is_ctrl(ctrl_addr_i);

   assign is_tx = radio_is(radio_state_i, `RFPBC_RADIO_TX);
   assign is_rx = radio_is(radio_state_i, `RFPBC_RADIO_RX);

   // output level from port mode, polarity and radio state
   rfpbc_level u_level (
      .single_port_i(port_arrangement_select),
      .invert_i(bias_polarity_invert),
      .radio_state_i(radio_state_i),
      .level_o(level)
   );

   // control word, writes to other register numbers are dropped
   always @* begin
      next_ctrl = ctrl;
      if (ctrl_take) begin
         next_ctrl = ctrl_wdata_i;
      end
   end

   // read path returns zero for unmapped register numbers
   always @* begin
      next_rdata = 16'h0000;
      if (ctrl_hit) begin
         next_rdata = ctrl;
      end
   end

   // bias pin released while disabled
   always @* begin
      next_bias_oe = 1'h0;
      next_bias_out = 1'h0;
      if (bias_out_enable) begin
         next_bias_oe = 1'h1;
         next_bias_out = level;
      end
   end

   // single port makes the input pair bidirectional
   always @* begin
      next_bidir = port_arrangement_select;
   end

   // receive switch, always on in dual port, on only while the shared pair receives
   always @* begin
      next_rx_switch_en = 1'h1;
      if (port_arrangement_select) begin
         next_rx_switch_en = is_rx;
      end
   end

   // transmit amplifier of the input pair, shared pair only
   always @* begin
      next_in_tx_amp_en = 1'h0;
      if (port_arrangement_select) begin
         next_in_tx_amp_en = is_tx;
      end
   end

   // transmit amplifier of the output pair, dual port only
   always @* begin
      next_out_tx_amp_en = 1'h0;
      if (!port_arrangement_select) begin
         next_out_tx_amp_en = is_tx;
      end
   end

   // control word register
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `RFPBC_CTRL_RESET;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // read data register
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_rdata_o <= `RFPBC_CTRL_RESET;
      end else begin
         ctrl_rdata_o <= next_rdata;
      end
   end

   // bias output level
   always @(posedge clk_i) begin
      if (rst_i) begin
         rf_bias_ctrl_out_o <= `RFPBC_OUT_RESET;
      end else begin
         rf_bias_ctrl_out_o <= next_bias_out;
      end
   end

   // bias output enable
   always @(posedge clk_i) begin
      if (rst_i) begin
         rf_bias_ctrl_oe_o <= `RFPBC_OUT_RESET;
      end else begin
         rf_bias_ctrl_oe_o <= next_bias_oe;
      end
   end

   // receive switch enable
   always @(posedge clk_i) begin
      if (rst_i) begin
         rf_in_rx_switch_en_o <= `RFPBC_OUT_RESET;
      end else begin
         rf_in_rx_switch_en_o <= next_rx_switch_en;
      end
   end

   // input pair transmit amplifier enable
   always @(posedge clk_i) begin
      if (rst_i) begin
         rf_in_tx_amp_en_o <= `RFPBC_OUT_RESET;
      end else begin
         rf_in_tx_amp_en_o <= next_in_tx_amp_en;
      end
   end

   // output pair transmit amplifier enable
   always @(posedge clk_i) begin
      if (rst_i) begin
         amp_out_tx_amp_en_o <= `RFPBC_OUT_RESET;
      end else begin
         amp_out_tx_amp_en_o <= next_out_tx_amp_en;
      end
   end

   // bidirectional input pair flag
   always @(posedge clk_i) begin
      if (rst_i) begin
         rf_in_bidir_o <= `RFPBC_OUT_RESET;
      end else begin
         rf_in_bidir_o <= next_bidir;
      end
   end
endmodule

// *** bench/rfpbc_asserts.sv ***
// checker for the rf port and bias control block
`timescale 1ns/1ns
module rfpbc_asserts (
   input wire clk_i,
   input wire rst_i,
   input wire ctrl_wr_i,
   input wire [7:0] ctrl_addr_i,
   input wire [15:0] ctrl_wdata_i,
   input wire [1:0] radio_state_i,
   input wire [15:0] ctrl_rdata_o,
   input wire rf_bias_ctrl_out_o,
   input wire rf_bias_ctrl_oe_o,
   input wire rf_in_rx_switch_en_o,
   input wire rf_in_tx_amp_en_o,
   input wire amp_out_tx_amp_en_o,
   input wire rf_in_bidir_o
);
   reg [15:0] c, q;
   reg [1:0] s;
   reg p;
   wire e = q[14], t = s == 2'h2, r = s == 2'h1, b = rf_bias_ctrl_out_o;
   always @(posedge clk_i) begin
      {p, s, q} <= {rst_i, radio_state_i, c};
      c <= rst_i ? 16'h0000 : ctrl_wr_i && ctrl_addr_i == 8'h07 ? ctrl_wdata_i : c;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i || p);
   a_bias_off: assert property (!e |-> !rf_bias_ctrl_oe_o && !b) else $error("bias not released");
   a_bias_on: assert property (e |-> rf_bias_ctrl_oe_o) else $error("bias not driven");
   a_single_lvl: assert property (e && q[12] |-> b == t) else $error("single level");
   a_dual_lvl: assert property (e && !q[12] && (t || r) |-> b == (t ^ q[13])) else $error("dual level");
   a_idle_low: assert property (e && !t && !r |-> !b) else $error("idle level");
   a_dual_paths: assert property (!q[12] |-> amp_out_tx_amp_en_o == t) else $error("output pair");
   a_port_sel: assert property (rf_in_bidir_o == q[12]) else $error("port select");
   a_read_zero: assert property (ctrl_addr_i != 8'h07 |=> ctrl_rdata_o == 16'h0000) else $error("read");
   a_read_back: assert property (ctrl_addr_i == 8'h07 |=> ctrl_rdata_o == q) else $error("read back");
   a_single_paths: assert property (q[12] |-> rf_in_rx_switch_en_o == r && rf_in_tx_amp_en_o == t &&
      !amp_out_tx_amp_en_o) else $error("shared pair");
   a_dual_rx: assert property (!q[12] |-> rf_in_rx_switch_en_o && !rf_in_tx_amp_en_o) else $error("input pair");
   cover property (e && q[12] && t);
   cover property (e && q[13] && r);
   cover property (!e && t);
   cover property (e && !q[12] && !t && !r);
endmodule
bind rfpbc_top rfpbc_asserts chk (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .ctrl_wr_i(ctrl_wr_i),
   .ctrl_addr_i(ctrl_addr_i),
   .ctrl_wdata_i(ctrl_wdata_i),
   .radio_state_i(radio_state_i),
   .ctrl_rdata_o(ctrl_rdata_o),
   .rf_bias_ctrl_out_o(rf_bias_ctrl_out_o),
   .rf_bias_ctrl_oe_o(rf_bias_ctrl_oe_o),
   .rf_in_rx_switch_en_o(rf_in_rx_switch_en_o),
   .rf_in_tx_amp_en_o(rf_in_tx_amp_en_o),
   .amp_out_tx_amp_en_o(amp_out_tx_amp_en_o),
   .rf_in_bidir_o(rf_in_bidir_o)
);

// *** bench/rfpbc_switch.sv ***
// antenna switch model on the bias pin, pull-down holds a released pin low
`timescale 1ns/1ns
module rfpbc_switch (
   input wire lvl_i,
   input wire oe_i,
   output wire pin_o
);
   assign pin_o = oe_i ? lvl_i : 1'b0;
endmodule

// *** bench/rfpbc_top_test.sv ***
// self-checking bench for the rf port and bias control block
`timescale 1ns/1ns
module rfpbc_top_test;
   reg clk_i = 1'h0;
   reg rst_i = 1'h1;
   reg ctrl_wr_i = 1'h0;
   reg [1:0] radio_state_i = 2'h0;
   reg [7:0] ctrl_addr_i = 8'h07;
   reg [15:0] ctrl_wdata_i = 16'h0000;
   wire [15:0] ctrl_rdata_o;
   wire rf_bias_ctrl_out_o;
   wire rf_bias_ctrl_oe_o;
   wire rf_in_rx_switch_en_o;
   wire rf_in_tx_amp_en_o;
   wire amp_out_tx_amp_en_o;
   wire rf_in_bidir_o;
   wire pin;
   wire [5:0] v = {rf_bias_ctrl_oe_o, pin, rf_in_rx_switch_en_o, rf_in_tx_amp_en_o,
      amp_out_tx_amp_en_o, rf_in_bidir_o};
   integer err_total = 0;
   integer total_checks = 0;
   always #20 clk_i = ~clk_i;
   rfpbc_top DUT (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ctrl_wr_i(ctrl_wr_i),
      .ctrl_addr_i(ctrl_addr_i),
      .ctrl_wdata_i(ctrl_wdata_i),
      .radio_state_i(radio_state_i),
      .ctrl_rdata_o(ctrl_rdata_o),
      .rf_bias_ctrl_out_o(rf_bias_ctrl_out_o),
      .rf_bias_ctrl_oe_o(rf_bias_ctrl_oe_o),
      .rf_in_rx_switch_en_o(rf_in_rx_switch_en_o),
      .rf_in_tx_amp_en_o(rf_in_tx_amp_en_o),
      .amp_out_tx_amp_en_o(amp_out_tx_amp_en_o),
      .rf_in_bidir_o(rf_in_bidir_o)
   );
   rfpbc_switch ant (
      .lvl_i(rf_bias_ctrl_out_o),
      .oe_i(rf_bias_ctrl_oe_o),
      .pin_o(pin)
   );
   task finish_test;
      if (err_total == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task cmp(input [5:0] x);
      total_checks = total_checks + 1;
      if (v !== x) begin
         err_total = err_total + 1;
         $display("[ERR] pins expected %b seen %b", x, v);
      end
   endtask
   task cmp_rd(input [15:0] x);
      total_checks = total_checks + 1;
      if (ctrl_rdata_o !== x) begin
         err_total = err_total + 1;
         $display("[ERR] read data expected %h seen %h", x, ctrl_rdata_o);
      end
   endtask
   task run(input [7:0] a, input [15:0] d, input [1:0] s);
      @(posedge clk_i) {ctrl_wr_i, ctrl_addr_i, ctrl_wdata_i, radio_state_i} <= {1'b1, a, d, s};
      @(posedge clk_i) ctrl_wr_i <= 0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   task t_single_tx;
      run(8'h07, 16'h7000, 2'h2);
      cmp(6'h35);
      cmp_rd(16'h7000);
   endtask
   task t_single_rx;
      run(8'h07, 16'h5000, 2'h1);
      cmp(6'h29);
   endtask
   task t_single_inv_rx;
      run(8'h07, 16'h7000, 2'h1);
      cmp(6'h29);
   endtask
   task t_single_idle;
      run(8'h07, 16'h5000, 2'h0);
      cmp(6'h21);
   endtask
   task t_dual_tx;
      run(8'h07, 16'h4000, 2'h2);
      cmp(6'h3a);
   endtask
   task t_dual_inv;
      run(8'h07, 16'h6000, 2'h2);
      cmp(6'h2a);
   endtask
   task t_dual_inv_rx;
      run(8'h07, 16'h6000, 2'h1);
      cmp(6'h38);
   endtask
   task t_reset_mid;
      @(posedge clk_i) rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      #1 cmp(6'h00);
      @(posedge clk_i) rst_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      #1 cmp(6'h0a);
      cmp_rd(16'h0000);
   endtask
   task t_dual_rx;
      run(8'h07, 16'h4000, 2'h1);
      cmp(6'h28);
   endtask
   task t_idle;
      run(8'h07, 16'h6000, 2'h3);
      cmp(6'h28);
   endtask
   task t_off;
      run(8'h07, 16'h3000, 2'h2);
      cmp(6'h05);
   endtask
   task t_unmapped;
      run(8'h06, 16'h4000, 2'h2);
      cmp(6'h05);
      cmp_rd(16'h0000);
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      #1 cmp(6'h00);
      @(posedge clk_i) rst_i <= 1'h0;
      t_single_tx;
      t_single_rx;
      t_single_inv_rx;
      t_single_idle;
      t_dual_tx;
      t_dual_inv;
      t_reset_mid;
      t_dual_inv_rx;
      t_dual_rx;
      t_idle;
      t_off;
      t_unmapped;
      finish_test;
   end
endmodule
